// *** verilog/elsf_pkg.sv ***
// shared constants, register map and state type of the encoder loss fallback
package elsf_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] TORQUE_PCT_OFS = 8'h08;
  localparam logic [7:0] TORQUE_NM_OFS = 8'h0C;
  localparam logic [7:0] EST_RPM_OFS = 8'h10;
  localparam logic [7:0] SP_INIT_OFS = 8'h14;
  // control fields
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RST = 1'b0;
  // status fields
  localparam int ST_SENSORLESS_BIT = 0;
  localparam int ST_WARN_BIT = 1;
  localparam int ST_AUTOTUNE_BIT = 2;
  localparam int ST_CONVERGING_BIT = 3;
  localparam int ST_ACCEL_BIT = 4;
  localparam int ST_SP_LOW_BIT = 5;
  localparam int ST_STATE_LSB = 8;
  // supervision figures
  localparam int THRESH_RPM = 300;
  localparam int REACH_PCT = 95;
  localparam int FULL_PCT = 100;
  localparam int CONV_TIME_MS = 100;
  localparam int CLK_MHZ = 250;
  localparam int CONV_CYCLES = CONV_TIME_MS * CLK_MHZ * 1000;
  // one-hot supervisor states
  typedef enum logic [4:0] {
    ELSF_STOPPED = 5'h01,
    ELSF_CONVERGE = 5'h02,
    ELSF_ACCEL = 5'h04,
    ELSF_ARMED = 5'h08,
    ELSF_SENSORLESS = 5'h10
  } elsf_state_t;
endpackage

// *** verilog/elsf_cmp_if.sv ***
// carrier between the supervisor and its speed comparator
`timescale 1ns/1ps
interface elsf_cmp_if #(
  parameter int SPD_W = 16
);
  logic signed [SPD_W-1:0] enc_rpm;
  logic signed [SPD_W-1:0] est_rpm;
  logic signed [SPD_W-1:0] sp_rpm;
  logic signed [SPD_W-1:0] sp_init_rpm;
  logic mismatch;
  logic reached;
  logic sp_ok;
  modport sup (
    output enc_rpm,
    output est_rpm,
    output sp_rpm,
    output sp_init_rpm,
    input mismatch,
    input reached,
    input sp_ok
  );
  modport cmp (
    input enc_rpm,
    input est_rpm,
    input sp_rpm,
    input sp_init_rpm,
    output mismatch,
    output reached,
    output sp_ok
  );
endinterface

// *** verilog/elsf_cmp.sv ***
// speed comparator: discrepancy, reach and setpoint level checks
`timescale 1ns/1ps
module elsf_cmp #(
  parameter int SPD_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  elsf_cmp_if.cmp cif
);
  localparam int MAG_W = SPD_W + 1;
  localparam int PRD_W = MAG_W + 8;
  localparam logic [MAG_W-1:0] THRESH = MAG_W'(elsf_pkg::THRESH_RPM);
  localparam logic [7:0] REACH = 8'(elsf_pkg::REACH_PCT);
  localparam logic [7:0] FULL = 8'(elsf_pkg::FULL_PCT);

  function automatic logic [MAG_W-1:0] mag(input logic signed [MAG_W-1:0] v);
    mag = v[MAG_W-1] ? MAG_W'(-v) : v;
  endfunction

  logic [MAG_W-1:0] diff_mag;
  logic [PRD_W-1:0] est_scaled;
  logic [PRD_W-1:0] sp_scaled;
  logic nxt_mismatch;
  logic nxt_reached;
  logic nxt_sp_ok;
  logic mismatch_ff;
  logic reached_ff;
  logic sp_ok_ff;

  always_comb begin
    // either sign of difference counts
    diff_mag = mag(MAG_W'(cif.enc_rpm) - MAG_W'(cif.est_rpm));
    nxt_mismatch = diff_mag > THRESH;
    // compare percentages without division
    est_scaled = PRD_W'(mag(MAG_W'(cif.est_rpm))) * PRD_W'(FULL);
    sp_scaled = PRD_W'(mag(MAG_W'(cif.sp_init_rpm))) * PRD_W'(REACH);
    nxt_reached = est_scaled >= sp_scaled;
    nxt_sp_ok = mag(MAG_W'(cif.sp_rpm)) >= THRESH;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mismatch_ff <= 1'b0;
      reached_ff <= 1'b0;
      sp_ok_ff <= 1'b0;
    end else begin
      mismatch_ff <= nxt_mismatch;
      reached_ff <= nxt_reached;
      sp_ok_ff <= nxt_sp_ok;
    end
  end

  assign cif.mismatch = mismatch_ff;
  assign cif.reached = reached_ff;
  assign cif.sp_ok = sp_ok_ff;
endmodule

// *** verilog/elsf_top.sv ***
// encoder loss fallback supervisor with register port
//
// Overview of operation
// - fallback enable bit, reset clear, permits automatic encoder to estimator handover.
// - estimator kept running and tracking at all times, encoder mode included.
// - enabled and speed gap above 300 rpm declares encoder fault, selects estimate.
// - after handover stay sensorless until the drive next stops.
// - while running after handover never return to encoder feedback.
// - raise a warning flag when the handover to sensorless takes place.
// - no handover at all while an autotune sequence is active.
// - no handover after each start until the estimator convergence time elapses.
// - no handover until estimated speed reaches 95% of initial setpoint.
// - no handover while the setpoint magnitude is below 300 rpm.
// - publish estimator torque both as percent and in newton metres.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module elsf_top #(
  parameter int SPD_W = 16,
  parameter int TRQ_W = 16,
  parameter int CONV_CYCLES = elsf_pkg::CONV_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [elsf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [elsf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [elsf_pkg::DATA_W-1:0] reg_rdata_ff,
  input wire logic drive_run,
  input wire logic autotune_active,
  input wire logic signed [SPD_W-1:0] setpoint_rpm,
  input wire logic signed [SPD_W-1:0] encoder_rpm,
  input wire logic signed [SPD_W-1:0] estimated_rotor_rpm,
  input wire logic signed [TRQ_W-1:0] estimator_torque_percent,
  input wire logic signed [TRQ_W-1:0] estimator_torque_nm,
  output logic signed [SPD_W-1:0] speed_feedback_ff,
  output logic sensorless_ff,
  output logic fallback_warning_ff,
  output logic estimator_run_ff,
  output logic signed [TRQ_W-1:0] estimated_torque_percent_ff,
  output logic signed [TRQ_W-1:0] estimated_torque_nm_ff
);
  localparam int CNT_W = 32;
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam int DW = elsf_pkg::DATA_W;

  elsf_cmp_if #(.SPD_W(SPD_W)) cif ();

  elsf_cmp #(
    .SPD_W(SPD_W)
  ) u_cmp (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .cif(cif)
  );

  // register access decode
  function automatic logic hit(
    input logic [elsf_pkg::ADDR_W-1:0] a,
    input logic [elsf_pkg::ADDR_W-1:0] ofs
  );
    hit = (a == ofs);
  endfunction

  // ---------------- control register ----------------
  logic enable_ff;
  logic nxt_enable;

  always_comb begin
    nxt_enable = enable_ff;
    if (reg_wr && hit(reg_addr, elsf_pkg::CTRL_OFS)) begin
      nxt_enable = reg_wdata[elsf_pkg::CTRL_EN_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      enable_ff <= elsf_pkg::CTRL_EN_RST;
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  // ---------------- supervisor state ----------------
  elsf_pkg::elsf_state_t state_ff;
  elsf_pkg::elsf_state_t nxt_state;
  logic [CNT_W-1:0] conv_cnt_ff;
  logic [CNT_W-1:0] nxt_conv_cnt;
  logic signed [SPD_W-1:0] sp_init_ff;
  logic signed [SPD_W-1:0] nxt_sp_init;
  logic run_d_ff;
  logic start;
  logic gate_ok;
  logic trip;

  // the estimator ignores our state, so it keeps tracking in encoder mode
  assign cif.enc_rpm = encoder_rpm;
  assign cif.est_rpm = estimated_rotor_rpm;
  assign cif.sp_rpm = setpoint_rpm;
  assign cif.sp_init_rpm = sp_init_ff;

  always_comb begin
    start = drive_run && !run_d_ff;
    // every guard must clear before a trip may act
    gate_ok = enable_ff && !autotune_active && cif.sp_ok;
    trip = gate_ok && cif.mismatch;
    nxt_state = state_ff;
    nxt_conv_cnt = conv_cnt_ff;
    nxt_sp_init = sp_init_ff;
    case (state_ff)
      elsf_pkg::ELSF_STOPPED: begin
        if (start) begin
          nxt_state = elsf_pkg::ELSF_CONVERGE;
          nxt_conv_cnt = '0;
          // initial setpoint is the one present at start
          nxt_sp_init = setpoint_rpm;
        end
      end
      elsf_pkg::ELSF_CONVERGE: begin
        if (conv_cnt_ff >= CONV_LAST) begin
          nxt_state = elsf_pkg::ELSF_ACCEL;
        end else begin
          nxt_conv_cnt = conv_cnt_ff + CNT_W'(1);
        end
      end
      elsf_pkg::ELSF_ACCEL: begin
        // reach flag lags one cycle behind the estimate
        if (cif.reached) begin
          nxt_state = elsf_pkg::ELSF_ARMED;
        end
      end
      elsf_pkg::ELSF_ARMED: begin
        if (trip) begin
          nxt_state = elsf_pkg::ELSF_SENSORLESS;
        end
      end
      elsf_pkg::ELSF_SENSORLESS: begin
        // no way back to encoder while running
        nxt_state = elsf_pkg::ELSF_SENSORLESS;
      end
      default: begin
        nxt_state = elsf_pkg::ELSF_STOPPED;
      end
    endcase
    // a stop ends every supervision cycle, sensorless included
    if (!drive_run) begin
      nxt_state = elsf_pkg::ELSF_STOPPED;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_ff <= elsf_pkg::ELSF_STOPPED;
      conv_cnt_ff <= '0;
      sp_init_ff <= '0;
      run_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      conv_cnt_ff <= nxt_conv_cnt;
      sp_init_ff <= nxt_sp_init;
      run_d_ff <= drive_run;
    end
  end

  // ---------------- feedback and flags ----------------
  logic signed [SPD_W-1:0] nxt_feedback;
  logic nxt_sensorless;
  logic nxt_warning;
  logic warn_set;
  logic warn_clr;

  always_comb begin
    nxt_sensorless = (nxt_state == elsf_pkg::ELSF_SENSORLESS);
    if (nxt_sensorless) begin
      nxt_feedback = estimated_rotor_rpm;
    end else begin
      nxt_feedback = encoder_rpm;
    end
    // a stop in the trip cycle cancels the handover, so no warning then
    warn_set = (state_ff == elsf_pkg::ELSF_ARMED) &&
               (nxt_state == elsf_pkg::ELSF_SENSORLESS);
    warn_clr = reg_wr && hit(reg_addr, elsf_pkg::STATUS_OFS) &&
               reg_wdata[elsf_pkg::ST_WARN_BIT];
    // set beats a clear landing in the same cycle
    nxt_warning = warn_set || (fallback_warning_ff && !warn_clr);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      speed_feedback_ff <= '0;
      sensorless_ff <= 1'b0;
      fallback_warning_ff <= 1'b0;
      estimator_run_ff <= 1'b0;
    end else begin
      speed_feedback_ff <= nxt_feedback;
      sensorless_ff <= nxt_sensorless;
      fallback_warning_ff <= nxt_warning;
      estimator_run_ff <= 1'b1;
    end
  end

  // ---------------- torque publication ----------------
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      estimated_torque_percent_ff <= '0;
      estimated_torque_nm_ff <= '0;
    end else begin
      estimated_torque_percent_ff <= estimator_torque_percent;
      estimated_torque_nm_ff <= estimator_torque_nm;
    end
  end

  // ---------------- read port ----------------
  logic [DW-1:0] status_word;
  logic [DW-1:0] nxt_rdata;

  always_comb begin
    status_word = '0;
    status_word[elsf_pkg::ST_SENSORLESS_BIT] = sensorless_ff;
    status_word[elsf_pkg::ST_WARN_BIT] = fallback_warning_ff;
    status_word[elsf_pkg::ST_AUTOTUNE_BIT] = autotune_active;
    status_word[elsf_pkg::ST_CONVERGING_BIT] =
      (state_ff == elsf_pkg::ELSF_CONVERGE);
    status_word[elsf_pkg::ST_ACCEL_BIT] = (state_ff == elsf_pkg::ELSF_ACCEL);
    status_word[elsf_pkg::ST_SP_LOW_BIT] = !cif.sp_ok;
    status_word[elsf_pkg::ST_STATE_LSB +: 5] = state_ff;
    nxt_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        elsf_pkg::CTRL_OFS: begin
          nxt_rdata[elsf_pkg::CTRL_EN_BIT] = enable_ff;
        end
        elsf_pkg::STATUS_OFS: begin
          nxt_rdata = status_word;
        end
        elsf_pkg::TORQUE_PCT_OFS: begin
          nxt_rdata = DW'(estimated_torque_percent_ff);
        end
        elsf_pkg::TORQUE_NM_OFS: begin
          nxt_rdata = DW'(estimated_torque_nm_ff);
        end
        elsf_pkg::EST_RPM_OFS: begin
          nxt_rdata = DW'(estimated_rotor_rpm);
        end
        elsf_pkg::SP_INIT_OFS: begin
          nxt_rdata = DW'(sp_init_ff);
        end
        default: begin
          nxt_rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      reg_rdata_ff <= '0;
    end else begin
      reg_rdata_ff <= nxt_rdata;
    end
  end
endmodule

// *** tb/elsf_top_properties.sv ***
// concurrent checks on the encoder loss fallback supervisor ports
`timescale 1ns/1ps
module elsf_top_properties #(
  parameter int SPD_W = 16,
  parameter int TRQ_W = 16,
  parameter int CONV_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic drive_run,
  input wire logic autotune_active,
  input wire logic signed [SPD_W-1:0] setpoint_rpm,
  input wire logic signed [SPD_W-1:0] encoder_rpm,
  input wire logic signed [SPD_W-1:0] estimated_rotor_rpm,
  input wire logic signed [TRQ_W-1:0] estimator_torque_percent,
  input wire logic signed [TRQ_W-1:0] estimator_torque_nm,
  input wire logic signed [SPD_W-1:0] speed_feedback_ff,
  input wire logic sensorless_ff,
  input wire logic fallback_warning_ff,
  input wire logic estimator_run_ff,
  input wire logic signed [TRQ_W-1:0] estimated_torque_percent_ff,
  input wire logic signed [TRQ_W-1:0] estimated_torque_nm_ff
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  int run_cnt_ff;
  int nxt_run_cnt;
  // saturates so a long run never wraps into a false early trip
  always_comb begin
    nxt_run_cnt = run_cnt_ff;
    if (!rst_b || !drive_run) nxt_run_cnt = 0;
    else if (run_cnt_ff < CONV_CYCLES + 8) nxt_run_cnt = run_cnt_ff + 1;
  end
  always_ff @(posedge core_clk) run_cnt_ff <= nxt_run_cnt;
  sequence trip_s;
    !sensorless_ff ##1 sensorless_ff;
  endsequence
  // the stop decision uses run as sampled in the same cycle as the state
  sequence held_s;
    sensorless_ff && drive_run;
  endsequence
  enc_fb_a: assert property (!sensorless_ff |->
    speed_feedback_ff == $past(encoder_rpm)) else $error("fb not encoder");
  est_fb_a: assert property (sensorless_ff |->
    speed_feedback_ff == $past(estimated_rotor_rpm))
    else $error("fb not estimate");
  trq_pub_a: assert property (
    estimated_torque_percent_ff == $past(estimator_torque_percent) &&
    estimated_torque_nm_ff == $past(estimator_torque_nm))
    else $error("torque not published");
  // the run flag is still in its reset value on the first edge after release
  est_run_a: assert property ($past(rst_b) |-> estimator_run_ff)
    else $error("estimator stopped");
  hold_sl_a: assert property (held_s |=> sensorless_ff)
    else $error("left sensorless while running");
  stop_exit_a: assert property (!drive_run |=> !sensorless_ff)
    else $error("sensorless after stop");
  warn_set_a: assert property (trip_s |-> fallback_warning_ff)
    else $error("no warning on handover");
  tune_block_a: assert property (trip_s |-> !$past(autotune_active))
    else $error("handover during autotune");
  conv_wait_a: assert property (trip_s |-> run_cnt_ff > CONV_CYCLES)
    else $error("handover before convergence");
  // both guard flags are registered, so the trip looks two cycles back
  sp_gate_a: assert property (trip_s |->
    $past(setpoint_rpm, 2) >= 300 || $past(setpoint_rpm, 2) <= -300)
    else $error("handover at low setpoint");
  speed_gap_a: assert property (trip_s |->
    $past(encoder_rpm, 2) - $past(estimated_rotor_rpm, 2) > 300 ||
    $past(encoder_rpm, 2) - $past(estimated_rotor_rpm, 2) < -300)
    else $error("handover without speed gap");
endmodule
bind elsf_top elsf_top_properties #(
  .SPD_W(SPD_W), .TRQ_W(TRQ_W), .CONV_CYCLES(CONV_CYCLES)
) u_props (
  .core_clk, .rst_b, .drive_run, .autotune_active, .setpoint_rpm,
  .encoder_rpm,
  .estimated_rotor_rpm, .estimator_torque_percent, .estimator_torque_nm,
  .speed_feedback_ff, .sensorless_ff, .fallback_warning_ff,
  .estimator_run_ff, .estimated_torque_percent_ff, .estimated_torque_nm_ff
);

// *** tb/elsf_motor_model.sv ***
// behavioural motor with shaft encoder and speed estimator
`timescale 1ns/1ps
module elsf_motor_model #(
  parameter int STEP = 100
) (
  input wire logic core_clk,
  input wire logic signed [15:0] target_rpm,
  input wire logic signed [15:0] enc_err_rpm,
  output logic signed [15:0] encoder_rpm,
  output logic signed [15:0] est_rpm,
  output logic signed [15:0] trq_pct,
  output logic signed [15:0] trq_nm
);
  logic signed [15:0] spd = 16'h0;
  // fixed slew so the reach guard sees a real ramp
  always @(posedge core_clk) begin
    if (spd + STEP <= target_rpm) spd <= spd + 16'(STEP);
    else if (spd - STEP >= target_rpm) spd <= spd - 16'(STEP);
    else spd <= target_rpm;
  end
  // a failed encoder shows as a fixed offset on its reading
  assign encoder_rpm = spd + enc_err_rpm;
  assign est_rpm = spd;
  assign trq_pct = spd >>> 2;
  assign trq_nm = spd >>> 3;
endmodule

// *** tb/elsf_top_tb.sv ***
// self-checking bench for the encoder loss fallback supervisor
`timescale 1ns/1ps
module elsf_top_tb;
  localparam int CONV = 20;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic drive_run = 1'b0;
  logic tune = 1'b0;
  logic signed [15:0] sp = 16'h0;
  logic signed [15:0] tgt = 16'h0;
  logic signed [15:0] ofs = 16'h0;
  logic signed [15:0] enc, est, tq_p, tq_n, fb;
  logic [31:0] rdata;
  logic sl, warn;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  always #2 core_clk = ~core_clk;
  elsf_motor_model u_motor (.core_clk(core_clk), .target_rpm(tgt),
    .enc_err_rpm(ofs), .encoder_rpm(enc), .est_rpm(est),
    .trq_pct(tq_p), .trq_nm(tq_n));
  elsf_top #(.CONV_CYCLES(CONV)) u_dut (.core_clk(core_clk),
    .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(rdata),
    .drive_run(drive_run), .autotune_active(tune), .setpoint_rpm(sp),
    .encoder_rpm(enc), .estimated_rotor_rpm(est),
    .estimator_torque_percent(tq_p), .estimator_torque_nm(tq_n),
    .speed_feedback_ff(fb), .sensorless_ff(sl),
    .fallback_warning_ff(warn), .estimator_run_ff(),
    .estimated_torque_percent_ff(), .estimated_torque_nm_ff());
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", x, rdata);
  endtask
  // one start-run-stop cycle with an encoder offset present from the start
  task automatic run_case(input int s, t, o, input logic en, tu, x);
    logic signed [15:0] e;
    logic [31:0] xs;
    wr(elsf_pkg::CTRL_OFS, {31'h0, en});
    sp <= 16'(s);
    tgt <= 16'(t);
    ofs <= 16'(o);
    tune <= tu;
    drive_run <= 1'b1;
    repeat (10) @(posedge core_clk);
    #1 chk("early", 32'h0, {31'h0, sl});
    // converging state code and flag, plus the autotune and low-setpoint bits
    xs = 32'h208 | {29'h0, tu, 2'b0};
    if (s < elsf_pkg::THRESH_RPM && s > -elsf_pkg::THRESH_RPM) begin
      xs = xs | 32'h20;
    end
    rd(elsf_pkg::STATUS_OFS, xs);
    repeat (CONV + 40) @(posedge core_clk);
    e = x ? 16'(t) : 16'(t + o);
    #1 chk("sensorless", {31'h0, x}, {31'h0, sl});
    chk("feedback", 32'(e), 32'(fb));
    @(posedge core_clk);
    ofs <= 16'h0;
    repeat (5) @(posedge core_clk);
    #1 chk("held", {31'h0, x}, {31'h0, sl});
    e = 16'(t) >>> 2;
    rd(elsf_pkg::TORQUE_PCT_OFS, 32'(e));
    e = 16'(t) >>> 3;
    rd(elsf_pkg::TORQUE_NM_OFS, 32'(e));
    rd(elsf_pkg::EST_RPM_OFS, 32'(16'(t)));
    rd(elsf_pkg::SP_INIT_OFS, 32'(16'(s)));
    @(posedge core_clk);
    drive_run <= 1'b0;
    tgt <= 16'h0;
    repeat (2) @(posedge core_clk);
    #1 chk("stopped", 32'h0, {31'h0, sl});
    chk("warning", {31'h0, x}, {31'h0, warn});
    wr(elsf_pkg::STATUS_OFS, 32'h2);
    #1 chk("cleared", 32'h0, {31'h0, warn});
  endtask
  // each case needs about 90 cycles, so this is several times the run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      test_done();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(elsf_pkg::CTRL_OFS, 32'h0);
    rd(elsf_pkg::STATUS_OFS, 32'h120);
    rd(8'h40, 32'h0);
    run_case(1000, 1000, 301, 1'b1, 1'b0, 1'b1);
    run_case(1000, 1000, 300, 1'b1, 1'b0, 1'b0);
    run_case(-1000, -1000, -400, 1'b1, 1'b0, 1'b1);
    run_case(1000, 1000, -400, 1'b1, 1'b0, 1'b1);
    run_case(1000, 1000, 500, 1'b0, 1'b0, 1'b0);
    run_case(1000, 1000, 500, 1'b1, 1'b1, 1'b0);
    run_case(299, 299, 500, 1'b1, 1'b0, 1'b0);
    run_case(1000, 940, 500, 1'b1, 1'b0, 1'b0);
    run_case(1000, 950, 500, 1'b1, 1'b0, 1'b1);
    test_done();
  end
endmodule
